/* File: src/ppp_pkg.sv */
// constants shared by the parallel-port host controller files
package ppp_pkg;

  // ==========================================================================
  // register map of the controller (byte addresses on AHB-Lite)
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MODE   = 8'h08;
  localparam logic [7:0] REG_BITCMD = 8'h0c;
  localparam logic [7:0] REG_SHADOW = 8'h10;

  // ==========================================================================
  // command register fields
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_OP_LSB   = 12;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ  = 2'h1;
  localparam logic [1:0] OP_RESET = 2'h2;

  // ==========================================================================
  // device locations selected by the two port-select bits
  localparam logic [1:0] SEL_FIRST  = 2'h0;
  localparam logic [1:0] SEL_SECOND = 2'h1;
  localparam logic [1:0] SEL_THIRD  = 2'h2;
  localparam logic [1:0] SEL_CTRL   = 2'h3;

  // ==========================================================================
  // control word layout of the device
  localparam int CW_FLAG    = 7;
  localparam int CW_MODEA   = 5;
  localparam int CW_A_IN    = 4;
  localparam int CW_CU_IN   = 3;
  localparam int CW_MODEB   = 2;
  localparam int CW_B_IN    = 1;
  localparam int CW_CL_IN   = 0;
  localparam int CW_BIT_LSB = 1;
  // mode helper register fields
  localparam int MH_A_IN  = 0;
  localparam int MH_CU_IN = 1;
  localparam int MH_B_IN  = 2;
  localparam int MH_CL_IN = 3;
  localparam int MH_MODEA = 4;
  localparam int MH_MODEB = 6;
  // bit command helper register fields
  localparam int BC_BIT_LSB = 0;
  localparam int BC_VALUE   = 3;
  // status register fields
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_SRQ_A   = 4;
  localparam int ST_SRQ_B   = 5;
  localparam int ST_RDATA   = 8;

  // ==========================================================================
  // bus cycle timing
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned T_SETUP_NS    = 20;
  localparam int unsigned T_STROBE_NS   = 150;
  localparam int unsigned T_HOLD_NS     = 20;
  localparam int unsigned T_RECOVER_NS  = 100;
  localparam int unsigned T_RESET_NS    = 500;
  localparam logic [7:0] T_SETUP_CYC =
    8'((T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] T_STROBE_CYC =
    8'((T_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] T_HOLD_CYC =
    8'((T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] T_RECOVER_CYC =
    8'((T_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] T_RESET_CYC =
    8'((T_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef enum logic [2:0] {
    ENG_IDLE    = 3'b000,
    ENG_SETUP   = 3'b001,
    ENG_STROBE  = 3'b010,
    ENG_HOLD    = 3'b011,
    ENG_RECOVER = 3'b100,
    ENG_RESET   = 3'b101
  } ppp_eng_state_t;

endpackage : ppp_pkg

/* File: src/ppp_bus_engine.sv */
// pin-level bus cycle engine that drives the parallel-port device
`timescale 1ns/1ps
`default_nettype none
module ppp_bus_engine (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [1:0] op,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  output logic            busy,
  output logic            done,
  output logic            illegal,
  output logic [7:0]      rdata_q,
  output logic            dev_cs_n,
  output logic            dev_rd_n,
  output logic            dev_wr_n,
  output logic            dev_reset,
  output logic            port_select_bit0,
  output logic            port_select_bit1,
  input  wire logic [7:0] host_data_bus_i,
  output logic [7:0]      host_data_bus_o,
  output logic            host_data_bus_oe_n
);

  ppp_pkg::ppp_eng_state_t state_q;
  logic [7:0] cnt_q;
  logic [1:0] op_q;
  logic [1:0] addr_q;
  logic [7:0] s1_q, s2_q, s3_q;
  logic       done_q, illegal_q;
  logic       go;
  logic [7:0] wdata_q;

  assign go = ce && start && (state_q == ppp_pkg::ENG_IDLE);

  // ==========================================================================
  // data bus input synchroniser
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
    end else if (ce) begin
      s1_q <= host_data_bus_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================================
  // cycle sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q   <= ppp_pkg::ENG_IDLE;
      cnt_q     <= 8'h00;
      op_q      <= ppp_pkg::OP_WRITE;
      addr_q    <= ppp_pkg::SEL_FIRST;
      rdata_q   <= 8'h00;
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
    end else if (ce) begin
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
      if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
      unique case (state_q)
        ppp_pkg::ENG_IDLE: begin
          if (start) begin
            op_q   <= op;
            addr_q <= addr;
            if (op == ppp_pkg::OP_RESET) begin
              state_q <= ppp_pkg::ENG_RESET;
              cnt_q   <= ppp_pkg::T_RESET_CYC;
            end else if (op == ppp_pkg::OP_READ && addr == ppp_pkg::SEL_CTRL)
            begin
              // refused without a strobe; only the port-select pins take the address
              done_q    <= 1'b1;
              illegal_q <= 1'b1;
            end else begin
              state_q <= ppp_pkg::ENG_SETUP;
              cnt_q   <= ppp_pkg::T_SETUP_CYC;
            end
          end
        end
        ppp_pkg::ENG_SETUP: begin
          if (cnt_q == 8'h00) begin
            state_q <= ppp_pkg::ENG_STROBE;
            cnt_q   <= ppp_pkg::T_STROBE_CYC;
          end
        end
        ppp_pkg::ENG_STROBE: begin
          // a read ends only once the settled bus value is stable
          if (cnt_q == 8'h00 && (op_q != ppp_pkg::OP_READ || s2_q == s3_q))
          begin
            if (op_q == ppp_pkg::OP_READ) begin
              rdata_q <= s3_q;
            end
            state_q <= ppp_pkg::ENG_HOLD;
            cnt_q   <= ppp_pkg::T_HOLD_CYC;
          end
        end
        ppp_pkg::ENG_HOLD: begin
          if (cnt_q == 8'h00) begin
            state_q <= ppp_pkg::ENG_RECOVER;
            cnt_q   <= ppp_pkg::T_RECOVER_CYC;
          end
        end
        ppp_pkg::ENG_RECOVER, ppp_pkg::ENG_RESET: begin
          if (cnt_q == 8'h00) begin
            state_q <= ppp_pkg::ENG_IDLE;
            done_q  <= 1'b1;
          end
        end
        default: state_q <= ppp_pkg::ENG_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // pin decode; select held low around the whole strobe
  always_comb begin
    dev_cs_n = !(state_q == ppp_pkg::ENG_SETUP ||
                 state_q == ppp_pkg::ENG_STROBE ||
                 state_q == ppp_pkg::ENG_HOLD);
    dev_rd_n = !(state_q == ppp_pkg::ENG_STROBE && op_q == ppp_pkg::OP_READ);
    dev_wr_n = !(state_q == ppp_pkg::ENG_STROBE && op_q == ppp_pkg::OP_WRITE);
    host_data_bus_oe_n = dev_cs_n || op_q != ppp_pkg::OP_WRITE;
  end
  assign dev_reset        = (state_q == ppp_pkg::ENG_RESET);
  assign port_select_bit0 = addr_q[0];
  assign port_select_bit1 = addr_q[1];
  assign host_data_bus_o  = wdata_q;
  assign busy             = (state_q != ppp_pkg::ENG_IDLE);
  assign done             = done_q;
  assign illegal          = illegal_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wdata_q <= 8'h00;
    end else if (go) begin
      wdata_q <= wdata;
    end
  end

  // ==========================================================================
  // checks
  a_no_ctrl_read: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !dev_rd_n |-> !(port_select_bit1 && port_select_bit0))
    else $error("read strobe at control address");
  a_strobe_in_select: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (!dev_rd_n || !dev_wr_n) |-> (!dev_cs_n && (dev_rd_n || dev_wr_n)))
    else $error("strobe outside select or both strobes low");
  a_write_drives_bus: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !dev_wr_n |-> (!host_data_bus_oe_n && $stable(host_data_bus_o)))
    else $error("write strobe without steady driven data");
  a_read_no_drive: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (!dev_rd_n || dev_cs_n) |-> host_data_bus_oe_n)
    else $error("bus driven during read or deselect");
  a_strobe_width: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $fell(dev_wr_n) |-> !dev_wr_n [*8])
    else $error("write strobe too short");
  a_reset_width: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $rose(dev_reset) |-> dev_reset [*8] ##1 (dev_cs_n && dev_rd_n))
    else $error("device reset pulse too short");
  a_illegal_quick: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (go && op == ppp_pkg::OP_READ && addr == ppp_pkg::SEL_CTRL)
    |=> (done && illegal && !busy))
    else $error("control read not refused at once");
  c_write: cover property (@(posedge clk_sys) disable iff (!rstn)
    $rose(dev_wr_n) ##[1:200] done);
  c_read: cover property (@(posedge clk_sys) disable iff (!rstn)
    $rose(dev_rd_n) ##[1:200] done);
  c_reset: cover property (@(posedge clk_sys) disable iff (!rstn)
    $fell(dev_reset));

endmodule : ppp_bus_engine
`default_nettype wire

/* File: src/ppp_host_ctrl.sv */
// host controller: AHB-Lite registers driving a programmable parallel port
// ============================================================================
`timescale 1ns/1ps
`default_nettype none
module ppp_host_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             dev_cs_n,
  output logic             dev_rd_n,
  output logic             dev_wr_n,
  output logic             dev_reset,
  output logic             port_select_bit0,
  output logic             port_select_bit1,
  input  wire logic [7:0]  host_data_bus_i,
  output logic [7:0]       host_data_bus_o,
  output logic             host_data_bus_oe_n,
  input  wire logic        service_request_a,
  input  wire logic        service_request_b
);

  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] hrdata_q;
  logic        eng_busy, eng_done, eng_illegal;
  logic [7:0]  eng_rdata;
  logic        start;
  logic [1:0]  start_op, start_addr;
  logic [7:0]  start_data;
  logic [13:0] cmd_q;
  logic        done_q, illegal_q, refused_q;
  logic [2:0]  srq_a_q, srq_b_q;
  logic        srq_a_q_lvl, srq_b_q_lvl;
  logic [7:0]  mode_word_q, third_shadow_q;
  logic        wr_cmd, wr_mode, wr_bit, wr_status, any_cmd;
  logic [7:0]  mode_word, bit_word;

  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend_q <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        wr_pend_q <= hwrite;
        wr_addr_q <= haddr[7:0];
        hrdata_q  <= 32'h0000_0000;
        if (!hwrite) begin
          unique case (haddr[7:0])
            ppp_pkg::REG_CMD:    hrdata_q <= {18'h00000, cmd_q};
            ppp_pkg::REG_STATUS: hrdata_q <= {16'h0000, eng_rdata,
                                  2'h0, srq_b_q_lvl, srq_a_q_lvl, refused_q,
                                  illegal_q, done_q, eng_busy};
            ppp_pkg::REG_SHADOW: hrdata_q <= {16'h0000, third_shadow_q,
                                               mode_word_q};
            default:             hrdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  assign wr_cmd    = wr_pend_q && wr_addr_q == ppp_pkg::REG_CMD;
  assign wr_mode   = wr_pend_q && wr_addr_q == ppp_pkg::REG_MODE;
  assign wr_bit    = wr_pend_q && wr_addr_q == ppp_pkg::REG_BITCMD;
  assign wr_status = wr_pend_q && wr_addr_q == ppp_pkg::REG_STATUS;
  assign any_cmd   = wr_cmd || wr_mode || wr_bit;

  // ==========================================================================
  // control word composition
  always_comb begin
    mode_word = 8'h00;
    mode_word[ppp_pkg::CW_FLAG]  = 1'b1;
    mode_word[ppp_pkg::CW_MODEA +: 2] =
      hwdata[ppp_pkg::MH_MODEA +: 2];
    mode_word[ppp_pkg::CW_A_IN]  = hwdata[ppp_pkg::MH_A_IN];
    mode_word[ppp_pkg::CW_CU_IN] = hwdata[ppp_pkg::MH_CU_IN];
    mode_word[ppp_pkg::CW_MODEB] = hwdata[ppp_pkg::MH_MODEB];
    mode_word[ppp_pkg::CW_B_IN]  = hwdata[ppp_pkg::MH_B_IN];
    mode_word[ppp_pkg::CW_CL_IN] = hwdata[ppp_pkg::MH_CL_IN];
    // bit command; also how request enables are set
    bit_word = 8'h00;
    bit_word[ppp_pkg::CW_BIT_LSB +: 3] = hwdata[ppp_pkg::BC_BIT_LSB +: 3];
    bit_word[0] = hwdata[ppp_pkg::BC_VALUE];
  end

  always_comb begin
    start      = ce && any_cmd && !eng_busy;
    start_op   = ppp_pkg::OP_WRITE;
    start_addr = ppp_pkg::SEL_CTRL;
    start_data = bit_word;
    if (wr_cmd) begin
      start_op   = hwdata[ppp_pkg::CMD_OP_LSB +: 2];
      start_addr = hwdata[ppp_pkg::CMD_ADDR_LSB +: 2];
      start_data = hwdata[ppp_pkg::CMD_DATA_LSB +: 8];
    end else if (wr_mode) begin
      start_data = mode_word;
    end
  end

  // ==========================================================================
  // status flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd_q     <= 14'h0000;
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (ce) begin
      if (start) begin
        cmd_q  <= {start_op, 2'h0, start_addr, start_data};
        done_q <= 1'b0;
      end
      if (eng_done) begin
        done_q <= 1'b1;
      end
      if (eng_illegal) begin
        illegal_q <= 1'b1;
      end else if (wr_status && hwdata[ppp_pkg::ST_ILLEGAL]) begin
        illegal_q <= 1'b0;
      end
      // a command while busy is dropped, not queued
      if (any_cmd && eng_busy) begin
        refused_q <= 1'b1;
      end else if (wr_status && hwdata[ppp_pkg::ST_REFUSED]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // shadow of the last mode word and the third port output latch
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_word_q    <= 8'h00;
      third_shadow_q <= 8'h00;
    end else if (start && start_op == ppp_pkg::OP_RESET) begin
      mode_word_q    <= 8'h00;
      third_shadow_q <= 8'h00;
    end else if (start && start_addr == ppp_pkg::SEL_CTRL &&
                 start_op == ppp_pkg::OP_WRITE) begin
      if (start_data[ppp_pkg::CW_FLAG]) begin
        mode_word_q    <= start_data;
        third_shadow_q <= 8'h00;
      end else begin
        third_shadow_q[start_data[ppp_pkg::CW_BIT_LSB +: 3]] <=
          start_data[0];
      end
    end else if (start && start_addr == ppp_pkg::SEL_THIRD &&
                 start_op == ppp_pkg::OP_WRITE) begin
      third_shadow_q <= start_data;
    end
  end

  // ==========================================================================
  // request lines from the third port, three-stage synchronised
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      srq_a_q     <= 3'h0;
      srq_b_q     <= 3'h0;
      srq_a_q_lvl <= 1'b0;
      srq_b_q_lvl <= 1'b0;
    end else if (ce) begin
      srq_a_q <= {srq_a_q[1:0], service_request_a};
      srq_b_q <= {srq_b_q[1:0], service_request_b};
      if (srq_a_q[1] == srq_a_q[2]) begin
        srq_a_q_lvl <= srq_a_q[2];
      end
      if (srq_b_q[1] == srq_b_q[2]) begin
        srq_b_q_lvl <= srq_b_q[2];
      end
    end
  end

  ppp_bus_engine u_engine (
    .clk_sys            (clk_sys),
    .rstn               (rstn),
    .ce                 (ce),
    .start              (start),
    .op                 (start_op),
    .addr               (start_addr),
    .wdata              (start_data),
    .busy               (eng_busy),
    .done               (eng_done),
    .illegal            (eng_illegal),
    .rdata_q            (eng_rdata),
    .dev_cs_n           (dev_cs_n),
    .dev_rd_n           (dev_rd_n),
    .dev_wr_n           (dev_wr_n),
    .dev_reset          (dev_reset),
    .port_select_bit0   (port_select_bit0),
    .port_select_bit1   (port_select_bit1),
    .host_data_bus_i    (host_data_bus_i),
    .host_data_bus_o    (host_data_bus_o),
    .host_data_bus_oe_n (host_data_bus_oe_n)
  );

  // ==========================================================================
  // checks
  a_mode_word_form: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (start && wr_mode) |-> (start_data[ppp_pkg::CW_FLAG] &&
      start_op == ppp_pkg::OP_WRITE && start_addr == ppp_pkg::SEL_CTRL))
    else $error("mode word lacks flag or wrong address");
  a_bit_word_form: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (start && wr_bit) |-> (!start_data[ppp_pkg::CW_FLAG] &&
      start_data[6:4] == 3'h0))
    else $error("bit command word malformed");
  a_mode_clears_c: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (start && wr_mode) |=> third_shadow_q == 8'h00)
    else $error("third port shadow not cleared by mode word");
  a_illegal_sticky: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (ce && eng_illegal) |=> illegal_q)
    else $error("illegal flag not raised");
  c_mode_then_bit: cover property (@(posedge clk_sys) disable iff (!rstn)
    (start && wr_mode) ##[1:300] (start && wr_bit));

endmodule : ppp_host_ctrl
`default_nettype wire

/* File: dv/ppp_dev_model.sv */
// behavioural model of the parallel-port device behind the controller
`timescale 1ns/1ps
`default_nettype none
module ppp_dev_model (
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       rst,
  input  wire logic [1:0] sel,
  input  wire logic [7:0] din,
  output logic      [7:0] dout,
  input  wire logic       strobe_a_n,
  input  wire logic       ack_b_n,
  input  wire logic [7:0] pins_a,
  output logic            req_a,
  output logic            req_b
);
  logic [7:0] pa_q, pb_q, pc_q, cw_q, rv;
  logic [7:0] last_q = 8'h00;
  // ==========
  // latches load on the closing edge of the write strobe
  always @(posedge wr_n or posedge rst) begin
    if (rst) begin
      {pa_q, pb_q, pc_q, cw_q} <= '0;
    end else if (!cs_n) begin
      case (sel)
        2'h0: pa_q <= din;
        2'h1: pb_q <= din;
        2'h2: pc_q <= din;
        default: if (din[7]) begin
          cw_q <= din;
          pa_q <= '0;
          pc_q <= '0;
        end else begin
          pc_q[din[3:1]] <= din[0];
        end
      endcase
    end
  end
  // ==========
  // mode 1 handshakes: group A strobed input, group B strobed output
  logic [7:0] in_a_q = 8'h00;
  logic       full_a = 1'b0, full_b_n = 1'b1, ra = 1'b0, rb = 1'b0;
  wire        a_sel = !cs_n && sel == 2'h0;
  wire        b_sel = !cs_n && sel == 2'h1;
  always @(negedge strobe_a_n or posedge rd_n or posedge rst) begin
    if (rst) full_a <= 1'b0;
    else if (!strobe_a_n) begin
      in_a_q <= pins_a;
      full_a <= 1'b1;
    end else if (a_sel) full_a <= 1'b0;
  end
  always @(posedge strobe_a_n or negedge rd_n or posedge rst) begin
    if (rst) ra <= 1'b0;
    else if (!rd_n) begin
      if (a_sel) ra <= 1'b0;
    end else if (full_a && pc_q[4]) ra <= 1'b1;
  end
  always @(posedge wr_n or negedge ack_b_n or posedge rst) begin
    if (rst) full_b_n <= 1'b1;
    else if (!ack_b_n) full_b_n <= 1'b1;
    else if (b_sel) full_b_n <= 1'b0;
  end
  always @(posedge ack_b_n or negedge wr_n or posedge rst) begin
    if (rst) rb <= 1'b0;
    else if (!wr_n) begin
      if (b_sel) rb <= 1'b0;
    end else if (full_b_n && pc_q[2]) rb <= 1'b1;
  end
  // requests leave on third-port bits 3 and 0
  assign req_a = ra;
  assign req_b = rb;
  // ==========
  // released bus shows the inverse of the last byte, never a stale copy
  assign rv = (sel == 2'h1) ? pb_q : (sel == 2'h2) ? pc_q :
              (cw_q[6:4] == 3'b011) ? in_a_q : pa_q;
  always @(posedge rd_n) last_q <= rv;
  assign dout = (!cs_n && !rd_n && sel != 2'h3) ? rv : ~last_q;
endmodule : ppp_dev_model
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the parallel-port host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, sa_n = 1'b1, ab_n = 1'b1, qa, qb;
  logic [7:0]  pins = 8'h00;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0]  htrans = '0, a;
  logic [2:0]  hsize = 3'h2;
  logic        hready, hresp, cs_n, rd_n, wr_n, drst, s0, s1, oe_n;
  logic [7:0]  d_o, d_dev, d, pc;
  logic [6:0]  m;
  logic [3:0]  b;
  int          fail_count = 0, check_count = 0, seed = 47647;
  int          i, n, rdf = 0, rl = 0;
  ppp_host_ctrl ppp_host_ctrl_inst (.clk_sys(clk_sys), .rstn(rstn),
    .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .dev_cs_n(cs_n),
    .dev_rd_n(rd_n), .dev_wr_n(wr_n), .dev_reset(drst),
    .port_select_bit0(s0), .port_select_bit1(s1),
    .host_data_bus_i(oe_n ? d_dev : d_o), .host_data_bus_o(d_o),
    .host_data_bus_oe_n(oe_n), .service_request_a(qa),
    .service_request_b(qb));
  ppp_dev_model ppp_dev_model_inst (.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .rst(drst), .sel({s1, s0}), .din(d_o), .dout(d_dev),
    .strobe_a_n(sa_n), .ack_b_n(ab_n), .pins_a(pins), .req_a(qa),
    .req_b(qb));
  always #2 clk_sys = ~clk_sys;
  always @(negedge rd_n) rdf++;
  always @(negedge clk_sys) begin
    if (drst === 1'b1) rl++;
    if (cs_n === 1'b1 && (oe_n !== 1'b1 || rd_n !== 1'b1 || wr_n !== 1'b1))
      chk("idle_pins", 0, 1);
  end
  // ==========
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (e !== g) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // polls until the engine reports done, giving up after 100 status reads
  task automatic wt();
    int k;
    for (k = 0; k < 100; k++) begin
      ahb(0, ppp_pkg::REG_STATUS, 0, r);
      if (r[1] === 1'b1 && r[0] === 1'b0) break;
    end
    chk("done_seen", 32'h2, r[1:0]);
  endtask : wt
  // strobe (g low) or acknowledge (g high) pulse, then a status read
  task automatic pls(input logic g, input logic [7:0] v);
    @(posedge clk_sys);
    pins <= v;
    @(posedge clk_sys);
    if (g) ab_n <= 1'b0;
    else sa_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    sa_n <= 1'b1;
    ab_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    ahb(0, ppp_pkg::REG_STATUS, 0, r);
  endtask : pls
  task automatic cmd(input logic [1:0] op, ad, input logic [7:0] wd);
    ahb(1, ppp_pkg::REG_CMD, {18'h0, op, 2'h0, ad, wd}, r);
    wt();
  endtask : cmd
  function automatic logic [7:0] mw(input logic [6:0] v);
    return {1'b1, v[5:4], v[0], v[1], v[6], v[2], v[3]};
  endfunction : mw
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // ==========
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    ahb(0, ppp_pkg::REG_STATUS, 0, r);
    chk("status_rst", 0, r);
    cmd(ppp_pkg::OP_RESET, 0, 0);
    chk("reset_len", 1, rl >= 125);
    for (i = 0; i < 6; i++) begin
      m = (i < 3) ? 7'(i * 15) : 7'($random(seed)) & 7'h5f;
      ahb(1, ppp_pkg::REG_MODE, {25'h0, m}, r);
      wt();
      chk("ctrl_word", mw(m), ppp_dev_model_inst.cw_q);
      ahb(0, ppp_pkg::REG_SHADOW, 0, r);
      chk("shadow", {8'h0, mw(m)}, r[15:0]);
    end
    ahb(1, ppp_pkg::REG_MODE, 0, r);
    wt();
    pc = 8'h00;
    for (i = 0; i < 6; i++) begin
      a = 2'(i % 3);
      d = 8'($random(seed));
      cmd(ppp_pkg::OP_WRITE, a, d);
      if (a == 2'h2) pc = d;
      cmd(ppp_pkg::OP_READ, a, 0);
      chk("read_back", d, r[15:8]);
    end
    for (i = 0; i < 8; i++) begin
      b = 4'($random(seed));
      ahb(1, ppp_pkg::REG_BITCMD, {28'h0, b}, r);
      wt();
      pc[b[2:0]] = b[3];
      chk("bit_cmd", pc, ppp_dev_model_inst.pc_q);
    end
    n = rdf;
    cmd(ppp_pkg::OP_READ, 2'h3, 0);
    chk("illegal", 1, r[2]);
    chk("no_strobe", n, rdf);
    ahb(0, ppp_pkg::REG_CMD, 0, r);
    chk("cmd_readback", 32'h1300, r);
    ahb(1, ppp_pkg::REG_CMD, 0, r);
    ahb(1, ppp_pkg::REG_CMD, 0, r);
    wt();
    chk("refused", 1, r[3]);
    ahb(1, ppp_pkg::REG_STATUS, 32'hc, r);
    ahb(0, ppp_pkg::REG_STATUS, 0, r);
    chk("flags_cleared", 0, r[3:2]);
    // group A strobed input, group B strobed output
    ahb(1, ppp_pkg::REG_MODE, 32'h51, r);
    wt();
    d = 8'($random(seed));
    pls(1'b0, d);
    chk("req_a_masked", 0, r[4]);
    ahb(1, ppp_pkg::REG_BITCMD, 32'hc, r);
    wt();
    pls(1'b0, d);
    chk("req_a_set", 1, r[4]);
    cmd(ppp_pkg::OP_READ, 2'h0, 0);
    chk("strobed_data", d, r[15:8]);
    chk("req_a_read", 0, r[4]);
    ahb(1, ppp_pkg::REG_BITCMD, 32'ha, r);
    wt();
    cmd(ppp_pkg::OP_WRITE, 2'h1, d);
    chk("out_full", 0, ppp_dev_model_inst.full_b_n);
    pls(1'b1, d);
    chk("out_taken", 1, ppp_dev_model_inst.full_b_n);
    chk("req_b_set", 1, r[5]);
    cmd(ppp_pkg::OP_WRITE, 2'h1, d);
    chk("req_b_write", 0, r[5]);
    ahb(0, 8'h20, 0, r);
    chk("unmapped", 0, r);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
